//--- logic/bct_slave.sv
// Slave-side cycle termination with early acknowledge support
`default_nettype none
// How it works
// - Early read ack; data within 90 ns
// - Suppress early ack while memory busy
// - Work correctly without the enable
// - In DMA, only memory honours enable
// - Enable to ack within one clock
// - Ack within 54 ns of enable
// - Read data valid within 303 ns
// - Internal access below 263.5 ns
// - Bus fault driven open collector only
// - Slave never drives clock extend
// - Bus fault asserted before acknowledge
// - Ack within 3.0 us of strobe
// - DMA read plus write under 3.0 us
// - Release ack within 50 ns of strobe high
// - Decode with strobe; only selected acks
// - Write: store data, then acknowledge
module bct_slave
  import bct_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  // Bus control; strobes and enable active low, sampled synchronously; address strobe also gates ack and data drive directly
  input wire logic bus_addr_strobe_n,
  input wire logic data_strobe_any_n,
  input wire logic lower_byte_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic read_not_write,
  input wire logic early_ack_enable_n,
  input wire logic dma_cycle,
  input wire logic [ADDR_W-1:0] addr,
  // Bus data pins
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Acknowledge, fault and spare pins (open collector)
  output logic transfer_ack_out,
  output logic transfer_ack_oe,
  output logic bus_fault_out,
  output logic bus_fault_oe,
  output logic clock_extend_req_out,
  output logic clock_extend_req_oe,
  input wire logic bus_fault_n_in,
  // Configuration
  input wire logic [ADDR_W-1:0] base,
  input wire logic [ADDR_W-1:0] mask,
  input wire logic is_memory,
  input wire logic fault_on_late,
  // Memory side
  input wire logic mem_busy,
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  output logic [1:0] mem_be,
  input wire logic mem_done,
  input wire logic [DATA_W-1:0] mem_rdata,
  // Status
  output logic selected,
  output logic late_fault
);
  bct_state_type state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic early_ok, next_early_ok;
  logic ack_drive, next_ack_drive;
  logic fault_drive, next_fault_drive;
  logic req, next_req;
  logic we, next_we;
  logic [ADDR_W-1:0] maddr, next_maddr;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [1:0] be, next_be;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic late, next_late;
  logic sel;

  // Saturating increment
  function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
    inc_sat = (v == '1) ? v : v + CNT_ONE;
  endfunction

  // Decode qualified by the strobe
  bct_select u_sel (
    .addr(addr),
    .bus_addr_strobe_n(bus_addr_strobe_n),
    .base(base),
    .mask(mask),
    .slave_selected(sel)
  );

  // Cycle sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_early_ok = early_ok;
    next_ack_drive = ack_drive;
    next_fault_drive = fault_drive;
    next_req = 1'b0;
    next_we = we;
    next_maddr = maddr;
    next_wdata = wdata;
    next_be = be;
    next_rdata = rdata;
    next_rvalid = rvalid;
    next_late = late;
    case (state)
      BCT_IDLE: begin
        next_cnt = CNT_ZERO;
        next_ack_drive = 1'b0;
        next_fault_drive = 1'b0;
        next_rvalid = 1'b0;
        if (sel) begin
          next_state = BCT_ACCESS;
          next_we = !read_not_write;
          next_maddr = addr;
          next_req = !read_not_write ? 1'b0 : 1'b1;
          // Early path only when memory is free and not DMA I/O
          next_early_ok = !mem_busy &&
                          (is_memory || !dma_cycle);
          next_late = 1'b0;
        end
      end
      BCT_ACCESS: begin
        next_cnt = inc_sat(cnt);
        // Writes start once the data strobes say data is valid
        if (we && !data_strobe_any_n && !req && !rvalid) begin
          next_req = 1'b1;
          next_wdata = data_in;
          next_be = {!upper_byte_strobe_n, !lower_byte_strobe_n};
          next_rvalid = 1'b1;
        end
        if (mem_done && !we) begin
          next_rdata = mem_rdata;
          next_rvalid = 1'b1;
        end
        if (mem_busy) begin
          next_early_ok = 1'b0;
        end
        if (bus_addr_strobe_n) begin
          next_state = BCT_IDLE;
        end else if (early_ok && !early_ack_enable_n && !we) begin
          // Data follows within the read window of the access
          next_ack_drive = 1'b1;
          next_state = BCT_ACK;
        end else if (mem_done) begin
          // Write stored or read data held: normal ack
          next_ack_drive = 1'b1;
          next_state = BCT_ACK;
        end else if (cnt >= ACK_LIMIT) begin
          next_late = 1'b1;
          next_fault_drive = fault_on_late;
          next_state = BCT_FAULT;
        end
      end
      BCT_ACK: begin
        if (mem_done && !we) begin
          next_rdata = mem_rdata;
          next_rvalid = 1'b1;
        end
        if (bus_addr_strobe_n) begin
          next_ack_drive = 1'b0;
          next_state = BCT_DONE;
        end else if (!bus_fault_n_in) begin
          next_ack_drive = 1'b0;
          next_state = BCT_DONE;
        end
      end
      BCT_FAULT: begin
        // Fault raised without any acknowledge
        if (bus_addr_strobe_n) begin
          next_fault_drive = 1'b0;
          next_state = BCT_DONE;
        end
      end
      BCT_DONE: begin
        next_ack_drive = 1'b0;
        next_fault_drive = 1'b0;
        next_rvalid = 1'b0;
        next_state = BCT_IDLE;
      end
      default: begin
        next_state = BCT_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= BCT_IDLE;
      cnt <= CNT_ZERO;
      early_ok <= 1'b0;
      ack_drive <= 1'b0;
      fault_drive <= 1'b0;
      req <= 1'b0;
      we <= 1'b0;
      maddr <= '0;
      wdata <= 16'h0000;
      be <= 2'h0;
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      late <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      early_ok <= next_early_ok;
      ack_drive <= next_ack_drive;
      fault_drive <= next_fault_drive;
      req <= next_req;
      we <= next_we;
      maddr <= next_maddr;
      wdata <= next_wdata;
      be <= next_be;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      late <= next_late;
    end
  end

  // Pin drive; acknowledge and fault only pull low
  assign transfer_ack_out = 1'b0;
  assign transfer_ack_oe = ack_drive && !bus_addr_strobe_n;
  assign bus_fault_out = 1'b0;
  assign bus_fault_oe = fault_drive;
  assign clock_extend_req_out = 1'b0;
  assign clock_extend_req_oe = 1'b0;
  assign data_out = rdata;
  assign data_oe = (state == BCT_ACK) && !we && rvalid &&
                   !bus_addr_strobe_n && !data_strobe_any_n;
  // Memory side
  assign mem_req = req;
  assign mem_we = we;
  assign mem_addr = maddr;
  assign mem_wdata = wdata;
  assign mem_be = be;
  assign selected = sel;
  assign late_fault = late;
endmodule
`default_nettype wire

//--- pkg/bct_pkg.sv
// Package of constants for the bus slave cycle-termination block
`default_nettype none
package bct_pkg;
  localparam int CLK_NS = 5;
  // Acknowledge, data and release timing
  localparam int EARLY_DATA_NS = 90;
  localparam int EARLY_DATA_CYC = EARLY_DATA_NS / CLK_NS;
  localparam int EARLY_ACK_NS = 54;
  localparam int EARLY_ACK_CYC = EARLY_ACK_NS / CLK_NS;
  localparam int READ_VALID_NS = 303;
  localparam int READ_VALID_CYC = READ_VALID_NS / CLK_NS;
  localparam int WRITE_HOLD_NS = 345;
  localparam int WRITE_HOLD_CYC = WRITE_HOLD_NS / CLK_NS;
  localparam int ACK_MAX_NS = 3000;
  localparam int ACK_MAX_CYC = ACK_MAX_NS / CLK_NS;
  localparam int RELEASE_NS = 50;
  localparam int RELEASE_CYC = RELEASE_NS / CLK_NS;
  // Widths
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] ACK_LIMIT = CNT_W'(ACK_MAX_CYC - 4);
  // Cycle states
  typedef enum logic [4:0] {
    BCT_IDLE = 5'h01,
    BCT_ACCESS = 5'h02,
    BCT_ACK = 5'h04,
    BCT_FAULT = 5'h08,
    BCT_DONE = 5'h10
  } bct_state_type;
endpackage
`default_nettype wire

//--- logic/bct_select.sv
// Address decode qualified by the address strobe
`default_nettype none
module bct_select
  import bct_pkg::*;
(
  // Bus address and strobe
  input wire logic [ADDR_W-1:0] addr,
  input wire logic bus_addr_strobe_n,
  // Window of this slave
  input wire logic [ADDR_W-1:0] base,
  input wire logic [ADDR_W-1:0] mask,
  // Result
  output logic slave_selected
);
  // Decode enabled only while the strobe is low
  assign slave_selected = !bus_addr_strobe_n &&
                          ((addr & mask) == (base & mask));
endmodule
`default_nettype wire

//--- dv/bct_slave_chk.sv
// Port assertions for the slave termination block
`default_nettype none
module bct_slave_chk (
  input wire logic mclk, reset, bus_addr_strobe_n, early_ack_enable_n,
  input wire logic read_not_write, dma_cycle, is_memory, mem_busy,
  input wire logic mem_done, mem_req, data_oe, selected,
  input wire logic transfer_ack_oe, clock_extend_req_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Quiet selected read, then the enable falling with no answer yet
  sequence quiet_rd;
    (selected && read_not_write && !mem_busy && !dma_cycle) [*8];
  endsequence
  sequence en_fall;
    !transfer_ack_oe && !mem_done && $fell(early_ack_enable_n);
  endsequence
  no_extend_a: assert property (!clock_extend_req_oe)
    else $error("clock extend driven");
  ack_release_a: assert property (
    bus_addr_strobe_n |-> !transfer_ack_oe) else $error("ack held");
  take_req_a: assert property (
    $rose(selected) && read_not_write |=> mem_req) else $error("no req");
  early_ack_a: assert property (
    quiet_rd ##0 en_fall |=> transfer_ack_oe) else $error("no early ack");
  suppress_a: assert property (
    (mem_busy && selected) ##0 en_fall |=> !transfer_ack_oe)
    else $error("early ack in refresh");
  dma_io_a: assert property (
    (dma_cycle && !is_memory && selected) ##0 en_fall |=> !transfer_ack_oe)
    else $error("early ack by io card");
  write_ack_a: assert property (
    $rose(transfer_ack_oe) && !read_not_write |-> $past(mem_done))
    else $error("write ack before store");
  read_data_a: assert property (
    $rose(transfer_ack_oe) && read_not_write |-> ##[0:18] data_oe)
    else $error("read data late");
endmodule
bind bct_slave bct_slave_chk chk_u (.mclk, .reset, .bus_addr_strobe_n,
  .early_ack_enable_n, .read_not_write, .dma_cycle, .is_memory, .mem_busy,
  .mem_done, .mem_req, .data_oe, .selected, .transfer_ack_oe,
  .clock_extend_req_oe);
`default_nettype wire

//--- dv/bct_master.sv
// Bus master model: strobes, early enable and answer wait
`default_nettype none
module bct_master
  import bct_pkg::*;
(
  input wire logic mclk, ack_n, fault_n, data_oe,
  input wire logic [DATA_W-1:0] data_out,
  output logic as_n, ds_n, lds_n, uds_n, rnw, en_n, dma,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {as_n, ds_n, lds_n, uds_n, rnw, en_n, dma} = 7'h7E;
    addr = '0;
    data_in = '0;
  end
  // One cycle; res 0 acked, 1 faulted, 2 no answer
  task automatic cycle(input logic rd, d, e, input logic [22:0] a,
      input logic [15:0] wd, output logic [15:0] rdat, output int res);
    int n;
    @(posedge mclk);
    #1 {addr, rnw, dma, data_in, as_n} = {a, rd, d, wd, 1'b0};
    if (rd) {ds_n, lds_n, uds_n} = 3'h0;
    n = 0;
    rdat = 'x;
    res = 2;
    // Strobe stays low until answer or 3.5 us
    // Limit stays above the 596-count fault timer
    while (n < 700 && res == 2) begin
      @(posedge mclk);
      #1 n++;
      if (n == 25) {ds_n, lds_n, uds_n} = 3'h0;
      if (n == 37 && e) en_n = 0;
      if (!fault_n) res = 1;
      else if (!ack_n) res = 0;
    end
    repeat (18) @(posedge mclk);
    #1 if (res == 0 && rd && data_oe) rdat = data_out;
    repeat (32) @(posedge mclk);
    #1 {as_n, ds_n, lds_n, uds_n, en_n} = 5'h1F;
    // Released bus must not show stale values
    data_in = ~wd;
    addr = ~a;
    repeat (28) @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the slave termination block
`default_nettype none
module testbench
  import bct_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset, bus_addr_strobe_n, data_strobe_any_n, dma_cycle;
  logic lower_byte_strobe_n, upper_byte_strobe_n, read_not_write;
  logic early_ack_enable_n, data_oe, transfer_ack_oe, bus_fault_oe;
  logic is_memory, fault_on_late, mem_busy, mem_req, mem_we, mem_done;
  logic selected, late_fault;
  logic [1:0] mem_be;
  logic [ADDR_W-1:0] addr, mem_addr;
  logic [DATA_W-1:0] data_in, data_out, mem_wdata, mem_rdata;
  logic [15:0] store [int];
  logic [15:0] exp_mem [int];
  int err_count = 0, tests_run = 0, cyc = 0, wait_n = 0, lat, dead;
  bct_slave dut_u (.mclk, .reset, .bus_addr_strobe_n, .data_strobe_any_n,
    .lower_byte_strobe_n, .upper_byte_strobe_n, .read_not_write,
    .early_ack_enable_n, .dma_cycle, .addr, .data_in, .data_out, .data_oe,
    .transfer_ack_out(), .transfer_ack_oe, .bus_fault_out(), .bus_fault_oe,
    .clock_extend_req_out(), .clock_extend_req_oe(),
    .bus_fault_n_in(!bus_fault_oe), .base(23'h200000), .mask(23'h7F0000),
    .is_memory, .fault_on_late, .mem_busy, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_be, .mem_done, .mem_rdata, .selected,
    .late_fault);
  bct_master m_u (.mclk, .ack_n(!transfer_ack_oe), .fault_n(!bus_fault_oe),
    .data_oe, .data_out, .as_n(bus_addr_strobe_n), .ds_n(data_strobe_any_n),
    .lds_n(lower_byte_strobe_n), .uds_n(upper_byte_strobe_n),
    .rnw(read_not_write), .en_n(early_ack_enable_n), .dma(dma_cycle),
    .addr, .data_in);
  always #2.5 mclk = ~mclk;
  function automatic logic [15:0] pat(input logic [22:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction
  // Memory behind the slave, answering after lat cycles
  always @(posedge mclk) begin
    mem_done <= 0;
    if (mem_req) wait_n <= lat;
    if (mem_req && mem_we) check("byte enables", 16'h3, 16'(mem_be));
    if (wait_n > 1) wait_n <= wait_n - 1;
    if (wait_n == 1 && !dead) begin
      mem_done <= 1;
      wait_n <= 0;
      mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : pat(mem_addr);
      if (mem_we) store[mem_addr] = mem_wdata;
    end
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      results();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One cycle through the master, compared with the model
  task automatic op(input logic rd, d, e, input logic [22:0] a,
      input logic [15:0] wd, input int er);
    logic [15:0] r;
    int res;
    m_u.cycle(rd, d, e, a, wd, r, res);
    check("outcome", 16'(er), 16'(res));
    if (rd && er == 0)
      check("read data", exp_mem.exists(a) ? exp_mem[a] : pat(a), r);
    if (!rd && er == 0) exp_mem[a] = wd;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    logic [22:0] a;
    mclk = 0;
    reset = 1;
    mem_busy = 1'b0;
    is_memory = 1'b1;
    fault_on_late = 1'b0;
    dead = 0;
    lat = 45;
    void'($urandom(38373));
    repeat (20) @(posedge mclk);
    #1 reset = 0;
    for (int i = 0; i < 8; i++) begin
      a = {7'h20, 16'($urandom)};
      op(0, 0, i[0], a, 16'($urandom), 0);
      op(1, 0, i[0], a, 16'h0, 0);
    end
    check("late fault", 16'h0, 16'(late_fault));
    $display("test early and plain cycles done");
    {mem_busy, lat} = {1'b1, 32'd60};
    op(1, 0, 1, a, 16'h0, 0);
    {mem_busy, is_memory} = 2'h0;
    op(1, 1, 1, a, 16'h0, 0);
    {is_memory, lat} = {1'b1, 32'd45};
    $display("test refresh and transfer cycles done");
    op(1, 0, 1, {7'h10, 16'($urandom)}, 16'h0, 2);
    dead = 1;
    fault_on_late = 1'b1;
    op(1, 0, 0, a, 16'h0, 1);
    check("late fault", 16'h1, 16'(late_fault));
    $display("test unselected and late cycles done");
    results();
  end
endmodule
`default_nettype wire
